/* File: board_pins.sv */
// Board model: resolves the level on every pad
module board_pins (
  input wire logic i_core_clk,
  input wire port_io_pkg::pad_port_t i_pad [4],
  input wire logic [7:0] i_ext_en [4],
  input wire logic [7:0] i_ext_val [4],
  output logic [7:0] o_level [4]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tog_q = 1'b0;
  // A pin with nothing on it wanders, so nobody may rely on its level
  always @(posedge i_core_clk)
  begin
    tog_q <= ~tog_q;
  end
  // Own driver wins, then the board driver, then the weak pull-up
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      o_level[p] = (i_pad[p].drive_oe & i_pad[p].drive_val)
        | (~i_pad[p].drive_oe & i_ext_en[p] & i_ext_val[p])
        | (~i_pad[p].drive_oe & ~i_ext_en[p] & (i_pad[p].pullup_en | {8{tog_q}}));
    end
  end
endmodule

/* File: port_io_pin_control.sv */
// Pin control for four byte-wide general-purpose ports with Avalon-MM register access
//
// Notes on behaviour
// R01: Unallocated pins on ports 0-3 act as GPIO through their data registers.
// R02: Crossbar-owned pins take output from the peripheral; data writes don't affect them.
// R03: Normal data reads return the level sampled at the pins.
// R04: Read-modify-write read phase returns the stored data latch instead.
// R05: All output drivers stay off until crossbar global enable is set.
// R06: Pins owned as peripheral inputs have drivers forced off.
// R07: One output mode bit per pin; one push-pull, zero open-drain; resets zero.
// R08: Push-pull drives low for zero, high for one.
// R09: Open-drain drives low for zero, floats for one.
// R10: Mode bits apply to crossbar pins, except forced open-drain pins.
// R11: Software makes a digital input with open-drain mode and data one.
// R12: Port 3 pins 6 and 7 have edge detectors with per-pin polarity bits.
// R13: Selected edge sets the pin's flag; enabled flags raise an interrupt request.
// R14: Every pin has a weak pull-up, enabled after reset.
// R15: Writing one to the global pull-up disable turns all pull-ups off.
// R16: A pin actively driving low has its pull-up switched off.
// R17: Port 1 input mode bit: zero analog, one digital; resets digital.
// R18: Analog port 1 pins have digital input cut and read zero.
// R19: Analog port 1 pins lose pull-up and are skipped by the crossbar.
// R20: Software should set analog pins open-drain with data one.
module port_io_pin_control #(
  parameter int NUM_PORTS = 4,
  parameter int PORT_WIDTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Crossbar allocation and peripheral drive
  input wire port_io_pkg::xbar_port_t i_xbar [4],
  // Pad inputs, sampled synchronously
  input wire logic [7:0] i_pad_in [4],
  // Pad controls
  output port_io_pkg::pad_port_t o_pad [4],
  // Port 1 pins the crossbar must skip (analog mode)
  output logic [7:0] o_port1_analog_input,
  // Edge interrupt requests for pins 6 and 7 of port 3
  output logic o_pin6_irq,
  output logic o_pin7_irq
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  // The register map packs one port per byte lane of a word, so no other shape fits
  if (NUM_PORTS != 4 || PORT_WIDTH != 8)
  begin : g_bad_param
    $error("port_io_pin_control supports exactly four 8-bit ports");
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] data_q [4];
  logic [7:0] out_mode_q [4];
  logic [7:0] port1_input_mode_bits_q;
  logic [7:0] crossbar_config_two_q;
  logic [7:0] port3_interrupt_flags_q;
  logic [1:0] irq_enable_q;
  logic [7:0] pin_level [4];
  logic [1:0] edge_prev_q;
  logic [1:0] edge_hit;
  logic ack_q;
  logic wr_go;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic xbar_on;
  logic pull_off;

  // Crossbar enable and global pull-up disable, both in the crossbar config byte
  assign xbar_on = crossbar_config_two_q[port_io_pkg::XBAR_ENABLE_BIT];
  assign pull_off = crossbar_config_two_q[port_io_pkg::PULLUP_DISABLE_BIT];

  // Writes land at the answer edge, the one edge at which the master sees
  // waitrequest low; earlier, a register could move before the transfer completes
  assign wr_go = i_avs_write & ack_q;

  // Digital input levels; analog port 1 pins read as zero
  // Pin state, not latch state, so owned pins read back what the peripheral drives
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      pin_level[p] = i_pad_in[p]; // R03
    end
    pin_level[1] = i_pad_in[1] & port1_input_mode_bits_q; // R18
  end

  // ****************************************************************
  // Bus access: one wait cycle per request keeps readdata registered
  // ****************************************************************
  // Answer flag: high in the one cycle in which waitrequest is low
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  // High in reset and idle; a master must never assume a fixed latency
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      // Low for exactly one cycle, the answer cycle
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_q);
    end
  end

  // Read multiplexer
  // Unmapped addresses read as zero rather than aliasing a register
  always_comb
  begin
    rd_d = port_io_pkg::UNMAPPED_READ;
    unique case (i_avs_address)
      port_io_pkg::OFF_PORT0_DATA: rd_d = {24'h000000, pin_level[0]}; // R03
      port_io_pkg::OFF_PORT1_DATA: rd_d = {24'h000000, pin_level[1]};
      port_io_pkg::OFF_PORT2_DATA: rd_d = {24'h000000, pin_level[2]};
      port_io_pkg::OFF_PORT3_DATA: rd_d = {24'h000000, pin_level[3]};
      port_io_pkg::OFF_PORT0_MODE: rd_d = {24'h000000, out_mode_q[0]};
      port_io_pkg::OFF_PORT1_MODE: rd_d = {24'h000000, out_mode_q[1]};
      port_io_pkg::OFF_PORT2_MODE: rd_d = {24'h000000, out_mode_q[2]};
      port_io_pkg::OFF_PORT3_MODE: rd_d = {24'h000000, out_mode_q[3]};
      port_io_pkg::OFF_PORT1_INMODE: rd_d = {24'h000000, port1_input_mode_bits_q};
      port_io_pkg::OFF_XBAR_CFG: rd_d = {24'h000000, crossbar_config_two_q};
      port_io_pkg::OFF_P3_IRQ: rd_d = {22'h0, irq_enable_q, port3_interrupt_flags_q};
      // Latch view of all four ports for the read phase of read-modify-write
      port_io_pkg::OFF_RMW_READ: rd_d = {data_q[3], data_q[2], data_q[1], data_q[0]}; // R04
      default: rd_d = port_io_pkg::UNMAPPED_READ;
    endcase
  end

  // Captured at the taking edge; stands through the answer cycle and after
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rd_q <= 32'h0000_0000;
    end
    else if (i_avs_read & ~ack_q)
    begin
      rd_q <= rd_d;
    end
  end

  assign o_avs_readdata = rd_q;

  // ****************************************************************
  // Port data latches and output modes
  // ****************************************************************
  // Data latches are written even for owned pins; ownership only hides them at the pad
  // Mode bits reset to open-drain, so no pin can drive high before software asks
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int p = 0; p < 4; p++)
      begin
        data_q[p] <= port_io_pkg::RST_DATA;
        out_mode_q[p] <= port_io_pkg::RST_OUT_MODE; // R07
      end
    end
    else if (wr_go & i_avs_byteenable[0])
    begin
      for (int p = 0; p < 4; p++)
      begin
        if (i_avs_address == port_io_pkg::OFF_PORT0_DATA + 6'(4 * p))
        begin
          data_q[p] <= i_avs_writedata[7:0]; // R01
        end
        if (i_avs_address == port_io_pkg::OFF_PORT0_MODE + 6'(4 * p))
        begin
          out_mode_q[p] <= i_avs_writedata[7:0]; // R07
        end
      end
      // Whole-word latch write serves the write-back of read-modify-write
      if (i_avs_address == port_io_pkg::OFF_RMW_READ)
      begin
        for (int p = 0; p < 4; p++)
        begin
          if (i_avs_byteenable[p])
          begin
            data_q[p] <= i_avs_writedata[8 * p +: 8]; // R04
          end
        end
      end
    end
    // Write-back with byte 0 masked still reaches ports 1 to 3
    else if (wr_go & (i_avs_address == port_io_pkg::OFF_RMW_READ))
    begin
      for (int p = 1; p < 4; p++)
      begin
        if (i_avs_byteenable[p])
        begin
          data_q[p] <= i_avs_writedata[8 * p +: 8];
        end
      end
    end
  end

  // Global crossbar and port 1 input mode configuration
  // Crossbar enable gates every driver; set it once the ownership inputs are settled
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      crossbar_config_two_q <= port_io_pkg::RST_XBAR; // R05 R14
      port1_input_mode_bits_q <= port_io_pkg::RST_IN_MODE; // R17
    end
    else if (wr_go & i_avs_byteenable[0])
    begin
      if (i_avs_address == port_io_pkg::OFF_XBAR_CFG)
      begin
        crossbar_config_two_q <= i_avs_writedata[7:0]; // R05 R15
      end
      if (i_avs_address == port_io_pkg::OFF_PORT1_INMODE)
      begin
        port1_input_mode_bits_q <= i_avs_writedata[7:0]; // R17
      end
    end
  end

  // ****************************************************************
  // Edge interrupts on port 3 pins 6 and 7
  // ****************************************************************
  // Previous sample resets low: with the reset polarity (falling) no edge can show
  // in the first cycle after reset, even on a pin the board holds low
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      edge_prev_q <= 2'b00;
    end
    else
    begin
      edge_prev_q <= i_pad_in[3][port_io_pkg::EDGE_PIN_HI:port_io_pkg::EDGE_PIN_LO];
    end
  end

  // Polarity one means rising, zero means falling
  always_comb
  begin
    edge_hit = 2'b00;
    for (int k = 0; k < 2; k++)
    begin
      if (port3_interrupt_flags_q[port_io_pkg::PIN6_POL_BIT + k])
      begin
        edge_hit[k] = i_pad_in[3][port_io_pkg::EDGE_PIN_LO + k] & ~edge_prev_q[k]; // R12
      end
      else
      begin
        edge_hit[k] = ~i_pad_in[3][port_io_pkg::EDGE_PIN_LO + k] & edge_prev_q[k]; // R12
      end
    end
  end

  // A write clears or sets flags, but a same-cycle edge wins over the clear,
  // so an edge arriving while software acknowledges is never lost
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      port3_interrupt_flags_q <= port_io_pkg::RST_P3_IRQ;
      irq_enable_q <= 2'b00;
    end
    else
    begin
      if (wr_go & (i_avs_address == port_io_pkg::OFF_P3_IRQ))
      begin
        if (i_avs_byteenable[0])
        begin
          port3_interrupt_flags_q <= i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1])
        begin
          irq_enable_q <= i_avs_writedata[9:8];
        end
      end
      if (edge_hit[0])
      begin
        port3_interrupt_flags_q[port_io_pkg::PIN6_FLAG_BIT] <= 1'b1; // R13
      end
      if (edge_hit[1])
      begin
        port3_interrupt_flags_q[port_io_pkg::PIN7_FLAG_BIT] <= 1'b1; // R13
      end
    end
  end

  // Requests follow flag and enable
  // Registered, so a request rises two edges after the pin edge
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_pin6_irq <= 1'b0;
      o_pin7_irq <= 1'b0;
    end
    else
    begin
      o_pin6_irq <= port3_interrupt_flags_q[port_io_pkg::PIN6_FLAG_BIT]
                    & irq_enable_q[port_io_pkg::PIN6_EN_BIT]; // R13
      o_pin7_irq <= port3_interrupt_flags_q[port_io_pkg::PIN7_FLAG_BIT]
                    & irq_enable_q[port_io_pkg::PIN7_EN_BIT]; // R13
    end
  end

  // ****************************************************************
  // Pad drive and pull-up
  // ****************************************************************
  // Registered so that every pad control leaves a flip-flop
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int p = 0; p < 4; p++)
      begin
        o_pad[p].drive_oe <= 8'h00; // R05
        o_pad[p].drive_val <= 8'h00;
        o_pad[p].pullup_en <= 8'hff; // R14
      end
      o_port1_analog_input <= 8'h00;
    end
    else
    begin
      for (int p = 0; p < 4; p++)
      begin
        for (int b = 0; b < 8; b++)
        begin
          logic owned;
          logic val;
          logic push;
          logic oe;
          owned = i_xbar[p].owned[b];
          // Analog port 1 pins are never handed to a peripheral
          if (p == 1 && !port1_input_mode_bits_q[b])
          begin
            owned = 1'b0; // R19
          end
          // Owned pins follow the peripheral; the latch keeps what software wrote
          val = owned ? i_xbar[p].value[b] : data_q[p][b]; // R01 R02
          // Bus lines and shift-mode receive pins never drive high
          push = out_mode_q[p][b] & ~(owned & i_xbar[p].force_od[b]); // R10
          // Open-drain drives only a low; crossbar off or peripheral input never drives
          oe = xbar_on & ~(owned & i_xbar[p].is_input[b]) & (push | ~val); // R05 R06 R08 R09
          o_pad[p].drive_oe[b] <= oe;
          o_pad[p].drive_val[b] <= val;
          // Pull-up dropped when globally off, when driving low, or analog
          o_pad[p].pullup_en[b] <= ~pull_off & ~(oe & ~val)
                                   & ~(p == 1 && !port1_input_mode_bits_q[b]); // R15 R16 R19
        end
      end
      o_port1_analog_input <= ~port1_input_mode_bits_q; // R19
    end
  end

endmodule

/* File: port_io_pin_control_assertions.sv */
// Checker bound to the port pin block
module port_io_pin_control_assertions (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire port_io_pkg::xbar_port_t i_xbar [4],
  input wire port_io_pkg::pad_port_t o_pad [4],
  input wire logic [7:0] o_port1_analog_input,
  input wire logic o_pin6_irq,
  input wire logic o_pin7_irq
);
  // ****
  // Helper state
  // ****
  logic xen_q;
  logic pud_q;
  logic cfg_wr;
  logic cfg_stage_q;
  logic [1:0] cfg_bits_q;
  logic [31:0] oe_v;
  logic [31:0] val_v;
  logic [31:0] pu_v;
  logic [31:0] inp_v;
  logic [31:0] od_v;
  // A config write lands at its answer edge; the pads follow one edge later
  assign cfg_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
    && (i_avs_address == port_io_pkg::OFF_XBAR_CFG);
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cfg_stage_q <= 1'b0;
      cfg_bits_q <= 2'b00;
      xen_q <= 1'b0;
      pud_q <= 1'b0;
    end
    else
    begin
      cfg_stage_q <= cfg_wr;
      if (cfg_wr)
      begin
        cfg_bits_q <= {i_avs_writedata[port_io_pkg::PULLUP_DISABLE_BIT],
          i_avs_writedata[port_io_pkg::XBAR_ENABLE_BIT]};
      end
      if (cfg_stage_q)
      begin
        xen_q <= cfg_bits_q[0];
        pud_q <= cfg_bits_q[1];
      end
    end
  end
  // Flatten the ports so one check covers every pin
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      oe_v[p*8 +: 8] = o_pad[p].drive_oe;
      val_v[p*8 +: 8] = o_pad[p].drive_val;
      pu_v[p*8 +: 8] = o_pad[p].pullup_en;
      inp_v[p*8 +: 8] = i_xbar[p].owned & i_xbar[p].is_input;
      od_v[p*8 +: 8] = i_xbar[p].owned & i_xbar[p].force_od;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // ****
  // Properties
  // ****
  bus_answer_a:
    assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  answer_once_a:
    assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  drivers_off_a:
    assert property (!xen_q |-> oe_v == 32'h0) else $error("driver on before enable");
  pullup_off_a:
    assert property (pud_q |-> pu_v == 32'h0) else $error("pull-up left on");
  low_fight_a:
    assert property ((oe_v & ~val_v & pu_v) == 32'h0) else $error("pull-up on low pin");
  input_pin_a:
    assert property (inp_v == $past(inp_v) |-> (oe_v & inp_v) == 32'h0)
    else $error("peripheral input pin driven");
  forced_od_a:
    assert property (od_v == $past(od_v) |-> (oe_v & val_v & od_v) == 32'h0)
    else $error("forced open-drain pin driven high");
  analog_pull_a:
    assert property ($stable(o_port1_analog_input) |->
      (o_port1_analog_input & o_pad[1].pullup_en) == 8'h00) else $error("analog pull-up on");
  reset_pads_a:
    assert property ($fell(i_rst) |-> pu_v == 32'hffff_ffff && oe_v == 32'h0
      && o_port1_analog_input == 8'h00 && !o_pin6_irq && !o_pin7_irq)
    else $error("wrong pad state after reset");
endmodule

bind port_io_pin_control port_io_pin_control_assertions i_chk (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_xbar(i_xbar),
  .o_pad(o_pad),
  .o_port1_analog_input(o_port1_analog_input),
  .o_pin6_irq(o_pin6_irq),
  .o_pin7_irq(o_pin7_irq)
);

/* File: port_io_pin_control_test.sv */
// Self-checking bench for the port pin block
module port_io_pin_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk;
  logic rst;
  logic [5:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  logic irq6;
  logic irq7;
  logic [7:0] analog;
  logic [7:0] ext_en [4];
  logic [7:0] ext_val [4];
  logic [7:0] pad_lvl [4];
  port_io_pkg::xbar_port_t xbar [4];
  port_io_pkg::pad_port_t pads [4];
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  port_io_pin_control i_dut (
    .i_core_clk(core_clk),
    .i_rst(rst),
    .i_avs_address(addr),
    .i_avs_read(rd_en),
    .i_avs_write(wr_en),
    .i_avs_writedata(wdata),
    .i_avs_byteenable(be),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq),
    .i_xbar(xbar),
    .i_pad_in(pad_lvl),
    .o_pad(pads),
    .o_port1_analog_input(analog),
    .o_pin6_irq(irq6),
    .o_pin7_irq(irq7)
  );
  board_pins i_board (
    .i_core_clk(core_clk),
    .i_pad(pads),
    .i_ext_en(ext_en),
    .i_ext_val(ext_val),
    .o_level(pad_lvl)
  );
  // ****
  // Helpers
  // ****
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // A hung handshake would stall the run forever
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t reg %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t pin %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    input logic [3:0] b, output logic [31:0] q);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    be <= b;
    rd_en <= !w;
    wr_en <= w;
    do
      @(posedge core_clk);
    while (waitreq !== 1'b0);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk_reg(q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // ****
  // Scenarios
  // ****
  // Reset state, a write with no byte enabled, an unmapped read
  task automatic t_reset;
    logic [31:0] q;
    bus(1'b1, port_io_pkg::OFF_PORT0_MODE, 32'hff, 4'h0, q);
    rd(port_io_pkg::OFF_PORT0_MODE, 32'h0);
    rd(port_io_pkg::OFF_PORT1_INMODE, 32'hff);
    rd(6'h30, 32'h0);
    rd(port_io_pkg::OFF_RMW_READ, 32'hffff_ffff);
    chk_pin(pads[2].pullup_en, 8'hff);
    chk_pin(pads[0].drive_oe, 8'h00);
  endtask
  // Both output modes; pin read differs from latch read on a held-low pin
  task automatic t_drive;
    ext_en[0] <= 8'h40;
    ext_val[0] <= 8'h00;
    wr(port_io_pkg::OFF_PORT0_DATA, 32'h5a);
    wr(port_io_pkg::OFF_PORT0_MODE, 32'h0f);
    tick(3);
    chk_pin(pads[0].drive_oe, 8'h00);
    wr(port_io_pkg::OFF_XBAR_CFG, 32'h40);
    tick(3);
    chk_pin(pads[0].drive_oe, 8'haf);
    chk_pin(pads[0].drive_oe & pads[0].drive_val, 8'h0a);
    rd(port_io_pkg::OFF_PORT0_DATA, 32'h1a);
    rd(port_io_pkg::OFF_RMW_READ, 32'hffff_ff5a);
  endtask
  // Peripheral input, forced open-drain and peripheral-driven pins
  task automatic t_xbar;
    xbar[2] <= {8'h07, 8'h01, 8'h02, 8'h06};
    wr(port_io_pkg::OFF_PORT2_MODE, 32'hff);
    wr(port_io_pkg::OFF_PORT2_DATA, 32'h00);
    tick(3);
    chk_pin(pads[2].drive_oe, 8'hfc);
    chk_pin(pads[2].drive_oe & pads[2].drive_val, 8'h04);
  endtask
  // Pin 7 is offered low by a peripheral but is analog, so it must stay undriven
  task automatic t_analog;
    xbar[1] <= {8'h80, 8'h00, 8'h00, 8'h00};
    ext_en[1] <= 8'hff;
    ext_val[1] <= 8'hff;
    wr(port_io_pkg::OFF_PORT1_DATA, 32'hff);
    wr(port_io_pkg::OFF_PORT1_INMODE, 32'h0f);
    tick(4);
    rd(port_io_pkg::OFF_PORT1_DATA, 32'h0f);
    chk_pin(analog, 8'hf0);
    chk_pin(pads[1].pullup_en, 8'h0f);
    chk_pin(pads[1].drive_oe, 8'h00);
  endtask
  // Wrong edges leave flags clear, right edges set them, enable masks
  task automatic t_edge;
    ext_en[3] <= 8'hff;
    ext_val[3] <= 8'h40;
    tick(4);
    wr(port_io_pkg::OFF_P3_IRQ, 32'h304);
    ext_val[3] <= 8'h80;
    tick(4);
    rd(port_io_pkg::OFF_P3_IRQ, 32'h304);
    ext_val[3] <= 8'h40;
    tick(4);
    rd(port_io_pkg::OFF_P3_IRQ, 32'h334);
    chk_pin({6'h00, irq7, irq6}, 8'h03);
    wr(port_io_pkg::OFF_P3_IRQ, 32'h134);
    tick(3);
    chk_pin({6'h00, irq7, irq6}, 8'h01);
    wr(port_io_pkg::OFF_P3_IRQ, 32'h104);
    tick(3);
    rd(port_io_pkg::OFF_P3_IRQ, 32'h104);
    chk_pin({6'h00, irq7, irq6}, 8'h00);
  endtask
  task automatic t_pull;
    wr(port_io_pkg::OFF_XBAR_CFG, 32'hc0);
    tick(3);
    chk_pin(pads[3].pullup_en, 8'h00);
  endtask
  initial
  begin
    rst = 1'b1;
    addr = 6'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      xbar[i] = '0;
      ext_en[i] = 8'h00;
      ext_val[i] = 8'h00;
    end
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_drive();
    t_xbar();
    t_analog();
    t_edge();
    t_pull();
    final_report();
  end
endmodule

/* File: port_io_pkg.sv */
// Package holding register map, field positions and shared types for the port pin block
package port_io_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [5:0] OFF_PORT0_DATA = 6'h00;
  localparam logic [5:0] OFF_PORT1_DATA = 6'h04;
  localparam logic [5:0] OFF_PORT2_DATA = 6'h08;
  localparam logic [5:0] OFF_PORT3_DATA = 6'h0c;
  localparam logic [5:0] OFF_PORT0_MODE = 6'h10;
  localparam logic [5:0] OFF_PORT1_MODE = 6'h14;
  localparam logic [5:0] OFF_PORT2_MODE = 6'h18;
  localparam logic [5:0] OFF_PORT3_MODE = 6'h1c;
  localparam logic [5:0] OFF_PORT1_INMODE = 6'h20;
  localparam logic [5:0] OFF_XBAR_CFG = 6'h24;
  localparam logic [5:0] OFF_P3_IRQ = 6'h28;
  localparam logic [5:0] OFF_RMW_READ = 6'h2c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int XBAR_ENABLE_BIT = 6;
  localparam int PULLUP_DISABLE_BIT = 7;
  localparam int PIN6_POL_BIT = 2;
  localparam int PIN7_POL_BIT = 3;
  localparam int PIN6_FLAG_BIT = 4;
  localparam int PIN7_FLAG_BIT = 5;
  localparam int PIN6_EN_BIT = 0;
  localparam int PIN7_EN_BIT = 1;
  localparam int EDGE_PIN_LO = 6;
  localparam int EDGE_PIN_HI = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_OUT_MODE = 8'h00;
  localparam logic [7:0] RST_IN_MODE = 8'hff;
  localparam logic [7:0] RST_XBAR = 8'h00;
  localparam logic [7:0] RST_P3_IRQ = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Crossbar view of one port: peripheral ownership and drive per pin
  typedef struct packed {
    logic [7:0] owned;
    logic [7:0] is_input;
    logic [7:0] force_od;
    logic [7:0] value;
  } xbar_port_t;

  // Pad controls of one port
  typedef struct packed {
    logic [7:0] drive_oe;
    logic [7:0] drive_val;
    logic [7:0] pullup_en;
  } pad_port_t;

endpackage
